// ---- hw/wrc_top.sv ----
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`include "wrc_cfg.svh"

module wrc_top
  import wrc_pkg::*;
#(
  parameter int LOW_SPEED_INTERNAL_OSCILLATOR_DIV_CYCLES = `WRC_LOW_SPEED_INTERNAL_OSCILLATOR_DIV_CYCLES,
  parameter int SRESET_CYCLES = `WRC_SRESET_CYCLES,
  parameter int LVR_QUALIFY_CYCLES = `WRC_LVR_QUALIFY_CYCLES
) (
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic WDT_CLEAR_I,
  input wire logic HALT_I,
  input wire logic POWER_DOWN_I,
  input wire logic LOW_SUPPLY_I,
  output logic DEVICE_RESET_O,
  output logic PC_SP_CLEAR_O,
  output logic PORT_PRESET_O,
  output logic TIME_OUT_FLAG_O,
  output logic POWER_DOWN_FLAG_O,
  output logic LOW_VOLTAGE_RESET_EN_O,
  output logic REFERENCE_ENABLE_O
);
  localparam int DIV_W = $clog2(LOW_SPEED_INTERNAL_OSCILLATOR_DIV_CYCLES + 1);
  localparam int SR_W = $clog2(SRESET_CYCLES + 1);
  localparam int LVQ_W = $clog2(LVR_QUALIFY_CYCLES + 1);

  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;
  logic lvs_meta_reg;
  logic lvs_sync_reg;
  logic [DIV_W-1:0] div_cnt_reg;
  logic low_speed_internal_oscillator_tick;
  logic [7:0] wdc_reg;
  logic [7:0] lvk_reg;
  logic ref_en_reg;
  logic wkey_flag_reg;
  logic lkey_flag_reg;
  logic lvr_flag_reg;
  logic to_flag_reg;
  logic pdf_flag_reg;
  wrc_sr_state_t sr_state_reg;
  wrc_sr_state_t sr_state_next;
  logic [SR_W-1:0] sr_cnt_reg;
  logic sr_wkey_reg;
  logic sr_lkey_reg;
  logic [LVQ_W-1:0] lvq_cnt_reg;
  logic lv_fire;
  logic dev_rst_reg;
  logic pcsp_reg;
  logic port_preset_reg;
  logic lvr_en_out_reg;
  logic [4:0] wdt_key;
  logic wdt_key_bad;
  logic lvk_bad;
  logic wdt_run;
  logic lvr_active;
  logic wdt_timeout;
  logic wdt_full;
  logic wdt_wake;
  logic sr_fire;
  logic full_rst;
  logic wdt_clear;
  logic wr_wdc;
  logic wr_flags;
  logic wr_lvk;
  logic wr_ref;

  wrc_reg_if reg_bus ();

  // Reset is applied at once and released through two stages.
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // The supply comparator is analog and asynchronous to the core clock.
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      lvs_meta_reg <= 1'b0;
      lvs_sync_reg <= 1'b0;
    end else begin
      lvs_meta_reg <= LOW_SUPPLY_I;
      lvs_sync_reg <= lvs_meta_reg;
    end
  end

  // Low-speed clock stand-in: one enable pulse per 32kHz period.
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_reg <= '0;
    end else if (low_speed_internal_oscillator_tick) begin
      div_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= div_cnt_reg + DIV_W'(1);
    end
  end
  assign low_speed_internal_oscillator_tick = div_cnt_reg == DIV_W'(LOW_SPEED_INTERNAL_OSCILLATOR_DIV_CYCLES - 1);

  wrc_axil u_axil (
    .clk_i(CORE_CLK_I),
    .rst_n_i(rst_n),
    .awaddr_i(S_AXI_AWADDR_I),
    .awvalid_i(S_AXI_AWVALID_I),
    .awready_o(S_AXI_AWREADY_O),
    .wdata_i(S_AXI_WDATA_I),
    .wstrb_i(S_AXI_WSTRB_I),
    .wvalid_i(S_AXI_WVALID_I),
    .wready_o(S_AXI_WREADY_O),
    .bresp_o(S_AXI_BRESP_O),
    .bvalid_o(S_AXI_BVALID_O),
    .bready_i(S_AXI_BREADY_I),
    .araddr_i(S_AXI_ARADDR_I),
    .arvalid_i(S_AXI_ARVALID_I),
    .arready_o(S_AXI_ARREADY_O),
    .rdata_o(S_AXI_RDATA_O),
    .rresp_o(S_AXI_RRESP_O),
    .rvalid_o(S_AXI_RVALID_O),
    .rready_i(S_AXI_RREADY_I),
    .regs(reg_bus.bus)
  );

  assign wr_wdc = reg_bus.wr_en && reg_bus.wr_addr == `WRC_OFS_WATCHDOG_CONTROL;
  assign wr_flags = reg_bus.wr_en && reg_bus.wr_addr == `WRC_OFS_RESET_CAUSE_FLAGS;
  assign wr_lvk = reg_bus.wr_en && reg_bus.wr_addr == `WRC_OFS_LOW_VOLTAGE_KEY;
  assign wr_ref = reg_bus.wr_en && reg_bus.wr_addr == `WRC_OFS_REFERENCE_CONTROL;

  // Key decoding.
  assign wdt_key = wdc_reg[`WRC_WDC_KEY_MSB:`WRC_WDC_KEY_LSB];
  assign wdt_run = wdt_key == `WRC_KEY_WDT_ENABLE;
  assign wdt_key_bad = !wdt_run && wdt_key != `WRC_KEY_WDT_DISABLE;
  assign lvk_bad = lvk_reg != `WRC_KEY_LV_ENABLE && lvk_reg != `WRC_KEY_LV_DISABLE;
  assign lvr_active = lvk_reg == `WRC_KEY_LV_ENABLE && !POWER_DOWN_I;

  // Reset sources.
  assign wdt_full = wdt_timeout && !POWER_DOWN_I;
  assign wdt_wake = wdt_timeout && POWER_DOWN_I;
  assign sr_fire = sr_state_reg == WRC_SR_FIRE;
  assign full_rst = sr_fire || lv_fire || wdt_full;
  assign wdt_clear = sr_fire || WDT_CLEAR_I || HALT_I || full_rst;

  wrc_wdt_counter u_wdt (
    .clk_i(CORE_CLK_I),
    .rst_n_i(rst_n),
    .tick_i(low_speed_internal_oscillator_tick),
    .run_i(wdt_run),
    .clear_i(wdt_clear),
    .period_sel_i(wdc_reg[`WRC_WDC_SEL_MSB:`WRC_WDC_SEL_LSB]),
    .timeout_o(wdt_timeout)
  );

  // Software reset sequencer shared by both key registers.
  always_comb begin
    sr_state_next = sr_state_reg;
    unique case (sr_state_reg)
      WRC_SR_IDLE: begin
        if (wdt_key_bad || lvk_bad) begin
          sr_state_next = WRC_SR_WAIT;
        end
      end
      WRC_SR_WAIT: begin
        if (sr_cnt_reg == SR_W'(SRESET_CYCLES - 1)) begin
          sr_state_next = WRC_SR_FIRE;
        end
      end
      WRC_SR_FIRE: begin
        sr_state_next = WRC_SR_IDLE;
      end
      default: begin
        sr_state_next = WRC_SR_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      sr_state_reg <= WRC_SR_IDLE;
    end else begin
      sr_state_reg <= sr_state_next;
    end
  end

  // Causes are latched so a repaired key still sets its flag when the pending reset fires.
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      sr_cnt_reg <= '0;
      sr_wkey_reg <= 1'b0;
      sr_lkey_reg <= 1'b0;
    end else if (sr_state_reg == WRC_SR_FIRE) begin
      sr_cnt_reg <= '0;
      sr_wkey_reg <= 1'b0;
      sr_lkey_reg <= 1'b0;
    end else if (sr_state_next == WRC_SR_WAIT) begin
      sr_cnt_reg <= sr_state_reg == WRC_SR_WAIT ? sr_cnt_reg + SR_W'(1) : '0;
      sr_wkey_reg <= sr_wkey_reg || wdt_key_bad;
      sr_lkey_reg <= sr_lkey_reg || lvk_bad;
    end
  end

  // Supply must stay low beyond the qualify count before it counts as a reset.
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      lvq_cnt_reg <= '0;
    end else if (!(lvr_active && lvs_sync_reg) || lv_fire) begin
      lvq_cnt_reg <= '0;
    end else begin
      lvq_cnt_reg <= lvq_cnt_reg + LVQ_W'(1);
    end
  end
  assign lv_fire = lvr_active && lvs_sync_reg
                   && lvq_cnt_reg == LVQ_W'(LVR_QUALIFY_CYCLES);

  // Watchdog control: reloaded by any full reset, kept over a sleep wake-up.
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      wdc_reg <= `WRC_WDC_RESET;
    end else if (full_rst) begin
      wdc_reg <= `WRC_WDC_RESET;
    end else if (wr_wdc) begin
      wdc_reg <= reg_bus.wr_data;
    end
  end

  // A real low-voltage reset keeps the key; the other full resets reload it.
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      lvk_reg <= `WRC_LVK_RESET;
    end else if (sr_fire || wdt_full) begin
      lvk_reg <= `WRC_LVK_RESET;
    end else if (wr_lvk) begin
      lvk_reg <= reg_bus.wr_data;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ref_en_reg <= 1'b0;
    end else if (full_rst) begin
      ref_en_reg <= 1'b0;
    end else if (wr_ref) begin
      ref_en_reg <= reg_bus.wr_data[`WRC_REF_ENABLE_BIT];
    end
  end

  // Reset cause flags: writing a one leaves a flag alone; a set beats a clear.
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      wkey_flag_reg <= 1'b0;
      lkey_flag_reg <= 1'b0;
      lvr_flag_reg <= 1'b0;
    end else begin
      if (sr_fire && sr_wkey_reg) begin
        wkey_flag_reg <= 1'b1;
      end else if (wr_flags && !reg_bus.wr_data[`WRC_FLAG_WDT_KEY]) begin
        wkey_flag_reg <= 1'b0;
      end
      if (sr_fire && sr_lkey_reg) begin
        lkey_flag_reg <= 1'b1;
      end else if (wr_flags && !reg_bus.wr_data[`WRC_FLAG_LV_KEY]) begin
        lkey_flag_reg <= 1'b0;
      end
      if (lv_fire) begin
        lvr_flag_reg <= 1'b1;
      end else if (wr_flags && !reg_bus.wr_data[`WRC_FLAG_LV]) begin
        lvr_flag_reg <= 1'b0;
      end
    end
  end

  // Status flags: power-on clears both, a low-voltage reset leaves both.
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      to_flag_reg <= 1'b0;
      pdf_flag_reg <= 1'b0;
    end else begin
      if (wdt_timeout) begin
        to_flag_reg <= 1'b1;
      end else if (HALT_I || WDT_CLEAR_I) begin
        to_flag_reg <= 1'b0;
      end
      if (HALT_I || wdt_wake) begin
        pdf_flag_reg <= 1'b1;
      end else if (WDT_CLEAR_I) begin
        pdf_flag_reg <= 1'b0;
      end
    end
  end

  // Output strobes; the reset values present the power-on state.
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      dev_rst_reg <= 1'b0;
      pcsp_reg <= 1'b1;
      port_preset_reg <= 1'b1;
      lvr_en_out_reg <= 1'b0;
    end else begin
      dev_rst_reg <= full_rst;
      pcsp_reg <= full_rst || wdt_wake;
      port_preset_reg <= full_rst;
      lvr_en_out_reg <= lvr_active;
    end
  end

  // Read mux; unused bits and unmapped offsets read zero.
  always_comb begin
    reg_bus.rd_data = 8'h00;
    unique case (reg_bus.rd_addr)
      `WRC_OFS_WATCHDOG_CONTROL: reg_bus.rd_data = wdc_reg;
      `WRC_OFS_RESET_CAUSE_FLAGS: begin
        reg_bus.rd_data[`WRC_FLAG_WDT_KEY] = wkey_flag_reg;
        reg_bus.rd_data[`WRC_FLAG_LV_KEY] = lkey_flag_reg;
        reg_bus.rd_data[`WRC_FLAG_LV] = lvr_flag_reg;
      end
      `WRC_OFS_LOW_VOLTAGE_KEY: reg_bus.rd_data = lvk_reg;
      `WRC_OFS_REFERENCE_CONTROL: reg_bus.rd_data[`WRC_REF_ENABLE_BIT] = ref_en_reg;
      `WRC_OFS_STATUS: begin
        reg_bus.rd_data[`WRC_STAT_TIME_OUT] = to_flag_reg;
        reg_bus.rd_data[`WRC_STAT_POWER_DOWN] = pdf_flag_reg;
        reg_bus.rd_data[`WRC_STAT_SRESET_PEND] = sr_state_reg != WRC_SR_IDLE;
      end
      default: reg_bus.rd_data = 8'h00;
    endcase
  end

  assign DEVICE_RESET_O = dev_rst_reg;
  assign PC_SP_CLEAR_O = pcsp_reg;
  assign PORT_PRESET_O = port_preset_reg;
  assign TIME_OUT_FLAG_O = to_flag_reg;
  assign POWER_DOWN_FLAG_O = pdf_flag_reg;
  assign LOW_VOLTAGE_RESET_EN_O = lvr_en_out_reg;
  assign REFERENCE_ENABLE_O = ref_en_reg;
endmodule // wrc_top

// ---- hw/wrc_cfg.svh ----
`ifndef WRC_CFG_SVH
`define WRC_CFG_SVH

// Register byte offsets.
`define WRC_OFS_WATCHDOG_CONTROL 8'h00
`define WRC_OFS_RESET_CAUSE_FLAGS 8'h04
`define WRC_OFS_LOW_VOLTAGE_KEY 8'h08
`define WRC_OFS_REFERENCE_CONTROL 8'h0C
`define WRC_OFS_STATUS 8'h10

// Reset values.
`define WRC_WDC_RESET 8'h57
`define WRC_LVK_RESET 8'h5A

// Watchdog control fields and keys.
`define WRC_WDC_KEY_MSB 7
`define WRC_WDC_KEY_LSB 3
`define WRC_WDC_SEL_MSB 2
`define WRC_WDC_SEL_LSB 0
`define WRC_KEY_WDT_DISABLE 5'h15
`define WRC_KEY_WDT_ENABLE 5'h0A
`define WRC_WDT_MIN_EXP 4'h8

// Low-voltage key codes.
`define WRC_KEY_LV_ENABLE 8'h5A
`define WRC_KEY_LV_DISABLE 8'hA5

// Bit positions.
`define WRC_FLAG_WDT_KEY 0
`define WRC_FLAG_LV_KEY 1
`define WRC_FLAG_LV 2
`define WRC_REF_ENABLE_BIT 3
`define WRC_STAT_TIME_OUT 0
`define WRC_STAT_POWER_DOWN 1
`define WRC_STAT_SRESET_PEND 2

// Timing.
`define WRC_CLK_PERIOD_NS 10
`define WRC_CORE_CLK_HZ 100000000
`define WRC_LOW_SPEED_INTERNAL_OSCILLATOR_HZ 32000
`define WRC_LOW_SPEED_INTERNAL_OSCILLATOR_DIV_CYCLES (`WRC_CORE_CLK_HZ / `WRC_LOW_SPEED_INTERNAL_OSCILLATOR_HZ)
`define WRC_SRESET_DELAY_NS 2000
`define WRC_SRESET_CYCLES \
  ((`WRC_SRESET_DELAY_NS + `WRC_CLK_PERIOD_NS - 1) / `WRC_CLK_PERIOD_NS)
`define WRC_LVR_QUALIFY_NS 120000
`define WRC_LVR_QUALIFY_CYCLES \
  ((`WRC_LVR_QUALIFY_NS + `WRC_CLK_PERIOD_NS - 1) / `WRC_CLK_PERIOD_NS)

`endif

// ---- hw/wrc_pkg.sv ----
package wrc_pkg;

  typedef enum logic [2:0] {
    WRC_SR_IDLE = 3'h1,
    WRC_SR_WAIT = 3'h2,
    WRC_SR_FIRE = 3'h4
  } wrc_sr_state_t;

  // Last count before overflow for a division of 2^(8+sel).
  function automatic logic [14:0] wrc_wdt_limit(input logic [2:0] sel);
    logic [15:0] span;
    span = 16'h0001 << ({1'b0, sel} + 4'h8);
    return 15'(span - 16'h0001);
  endfunction

endpackage

// ---- hw/wrc_reg_if.sv ----
interface wrc_reg_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;

  modport bus (output wr_en, output wr_addr, output wr_data, output rd_addr,
               input rd_data);
  modport regs (input wr_en, input wr_addr, input wr_data, input rd_addr,
                output rd_data);
endinterface

// ---- hw/wrc_axil.sv ----
module wrc_axil
  import wrc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [7:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  wrc_reg_if.bus regs
);
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [7:0] w_data_reg;
  logic w_lane0_reg;
  logic bvalid_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;

  // Address and data are taken in either order; the response waits for both.
  assign awready_o = !aw_held_reg && !bvalid_reg;
  assign wready_o = !w_held_reg && !bvalid_reg;
  assign arready_o = !rvalid_reg;
  assign bvalid_o = bvalid_reg;
  assign bresp_o = 2'h0;
  assign rvalid_o = rvalid_reg;
  assign rdata_o = rdata_reg;
  assign rresp_o = 2'h0;

  // Only byte lane 0 carries register bits; a write without it stores nothing.
  assign regs.wr_en = aw_held_reg && w_held_reg && w_lane0_reg;
  assign regs.wr_addr = aw_addr_reg;
  assign regs.wr_data = w_data_reg;
  assign regs.rd_addr = araddr_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (aw_held_reg && w_held_reg) begin
      aw_held_reg <= 1'b0;
    end else if (awvalid_i && awready_o) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= awaddr_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_lane0_reg <= 1'b0;
    end else if (aw_held_reg && w_held_reg) begin
      w_held_reg <= 1'b0;
    end else if (wvalid_i && wready_o) begin
      w_held_reg <= 1'b1;
      w_data_reg <= wdata_i[7:0];
      w_lane0_reg <= wstrb_i[0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bvalid_reg <= 1'b0;
    end else if (aw_held_reg && w_held_reg) begin
      bvalid_reg <= 1'b1;
    end else if (bready_i) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else if (arvalid_i && arready_o) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h00_0000, regs.rd_data};
    end else if (rready_i) begin
      rvalid_reg <= 1'b0;
    end
  end
endmodule // wrc_axil

// ---- hw/wrc_wdt_counter.sv ----
module wrc_wdt_counter
  import wrc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic run_i,
  input wire logic clear_i,
  input wire logic [2:0] period_sel_i,
  output logic timeout_o
);
  logic [14:0] count_reg;
  logic timeout_reg;
  logic at_limit;

  assign at_limit = count_reg >= wrc_wdt_limit(period_sel_i);
  assign timeout_o = timeout_reg;

  // The count survives a period change, so a shorter period can end early.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_reg <= 15'h0000;
    end else if (clear_i) begin
      count_reg <= 15'h0000;
    end else if (run_i && tick_i) begin
      count_reg <= at_limit ? 15'h0000 : count_reg + 15'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timeout_reg <= 1'b0;
    end else begin
      timeout_reg <= run_i && tick_i && at_limit && !clear_i;
    end
  end
endmodule // wrc_wdt_counter

// ---- bench/wrc_top_chk.sv ----
module wrc_top_chk (
  input wire logic CORE_CLK_I,
  input wire logic [1:0] S_AXI_RRESP_O,
  input wire logic RSTN_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic POWER_DOWN_I,
  input wire logic DEVICE_RESET_O,
  input wire logic PC_SP_CLEAR_O,
  input wire logic PORT_PRESET_O,
  input wire logic TIME_OUT_FLAG_O,
  input wire logic LOW_VOLTAGE_RESET_EN_O
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);
  chk_bvalid_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O)
    else $error("write response dropped early");
  chk_rvalid_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O)
    else $error("read data dropped early");
  chk_bresp_okay: assert property (S_AXI_BVALID_O |-> S_AXI_BRESP_O == 2'h0)
    else $error("write response not okay");
  chk_rresp_okay: assert property (S_AXI_RVALID_O |-> S_AXI_RRESP_O == 2'h0)
    else $error("read response not okay");
  chk_aw_refused: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O)
    else $error("address taken while response pending");
  chk_reset_pulse: assert property (DEVICE_RESET_O |=> !DEVICE_RESET_O)
    else $error("device reset longer than one cycle");
  // Ports and program counter are preset in the very cycle the reset strobe stands.
  chk_reset_ports: assert property (DEVICE_RESET_O |-> PORT_PRESET_O && PC_SP_CLEAR_O)
    else $error("port preset missing on reset");
  chk_lvr_sleep_off: assert property (POWER_DOWN_I |=> !LOW_VOLTAGE_RESET_EN_O)
    else $error("low-voltage reset active in sleep");
  chk_timeout_clears_pc: assert property ($rose(TIME_OUT_FLAG_O) |-> PC_SP_CLEAR_O)
    else $error("time-out without pc clear");
  cover property (DEVICE_RESET_O);
  cover property (POWER_DOWN_I && PC_SP_CLEAR_O);
  cover property (S_AXI_BVALID_O && S_AXI_BREADY_I);
endmodule // wrc_top_chk

bind wrc_top wrc_top_chk u_chk (.CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I),
  .S_AXI_RRESP_O(S_AXI_RRESP_O),
  .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_BRESP_O(S_AXI_BRESP_O),
  .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
  .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
  .POWER_DOWN_I(POWER_DOWN_I), .DEVICE_RESET_O(DEVICE_RESET_O),
  .PC_SP_CLEAR_O(PC_SP_CLEAR_O), .PORT_PRESET_O(PORT_PRESET_O),
  .TIME_OUT_FLAG_O(TIME_OUT_FLAG_O), .LOW_VOLTAGE_RESET_EN_O(LOW_VOLTAGE_RESET_EN_O));

// ---- bench/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic clr = 0, hlt = 0, pd = 0, low = 0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat;
  logic awr, wrr, bv, arr, rv, drst, pcs, pps, tof, power_down_flag, lven, refe;
  logic [7:0] d;
  int fail_count = 0, comparisons = 0, nrst = 0, npc = 0, n0, p0;
  always #5 clk = ~clk;
  // Shortened counts keep the run brief; every expected figure below derives from them.
  wrc_top #(.LOW_SPEED_INTERNAL_OSCILLATOR_DIV_CYCLES(4), .SRESET_CYCLES(8), .LVR_QUALIFY_CYCLES(16)) u_wrc_top (
    .CORE_CLK_I(clk), .RSTN_I(rstn), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wrr), .S_AXI_BRESP_O(), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry),
    .WDT_CLEAR_I(clr), .HALT_I(hlt), .POWER_DOWN_I(pd), .LOW_SUPPLY_I(low),
    .DEVICE_RESET_O(drst), .PC_SP_CLEAR_O(pcs), .PORT_PRESET_O(pps),
    .TIME_OUT_FLAG_O(tof), .POWER_DOWN_FLAG_O(power_down_flag), .LOW_VOLTAGE_RESET_EN_O(lven),
    .REFERENCE_ENABLE_O(refe));
  always @(posedge clk) begin
    if (drst === 1'b1) nrst <= nrst + 1;
    if (pcs === 1'b1) npc <= npc + 1;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    awa <= a;
    wd <= {24'h0, v};
    awv <= 1;
    wv <= 1;
    bry <= 1;
    do begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wrr) wv <= 0;
    end while (bv !== 1'b1);
    bry <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    ara <= a;
    arv <= 1;
    rry <= 1;
    do begin
      @(posedge clk);
      if (arr) arv <= 0;
    end while (rv !== 1'b1);
    rry <= 0;
    check(rdat, {24'h0, exp});
  endtask
  task automatic pulse(input bit h);
    if (h) hlt <= 1;
    else clr <= 1;
    @(posedge clk);
    hlt <= 0;
    clr <= 0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    idle(40000);
    fail_count++;
    summarize();
  end
  initial begin
    idle(3);
    check(pps, 1);
    check(pcs, 1);
    rstn <= 1;
    idle(4);
    check(tof, 0);
    check(power_down_flag, 0);
    rd(8'h00, 8'h57);
    rd(8'h08, 8'h5A);
    rd(8'h04, 8'h00);
    rd(8'h14, 8'h00);
    wr(8'h0C, 8'hFF);
    rd(8'h0C, 8'h08);
    check(refe, 1);
    wr(8'h04, 8'hFF);
    rd(8'h04, 8'h00);
    // Clear first so the short period starts from zero, not from an old count.
    for (int s = 0; s < 2; s++) begin
      pulse(0);
      wr(8'h00, {5'h0A, 3'(s)});
      n0 = nrst;
      idle((1024 << s) - 20);
      check(nrst, n0);
      idle(50);
      check(nrst, n0 + 1);
      check(tof, 1);
      rd(8'h00, 8'h57);
      rd(8'h10, 8'h01);
    end
    pulse(0);
    wr(8'h00, 8'h50);
    pd <= 1;
    n0 = nrst;
    p0 = npc;
    idle(1060);
    check(npc, p0 + 1);
    check(nrst, n0);
    check(power_down_flag, 1);
    check(lven, 0);
    rd(8'h00, 8'h50);
    rd(8'h10, 8'h03);
    pd <= 0;
    wr(8'h00, 8'hA8);
    idle(3000);
    check(nrst, n0);
    wr(8'h00, 8'h50);
    for (int i = 0; i < 6; i++) begin
      pulse(i % 2);
      idle(700);
    end
    check(nrst, n0);
    wr(8'h00, 8'hA8);
    check(lven, 1);
    low <= 1;
    idle(12);
    low <= 0;
    idle(10);
    check(nrst, n0);
    wr(8'h08, 8'hA5);
    idle(2);
    check(lven, 0);
    low <= 1;
    idle(30);
    low <= 0;
    check(nrst, n0);
    wr(8'h08, 8'h5A);
    idle(2);
    low <= 1;
    idle(28);
    low <= 0;
    idle(4);
    check(nrst, n0 + 1);
    rd(8'h04, 8'h04);
    rd(8'h08, 8'h5A);
    wr(8'h04, 8'h00);
    wr(8'h00, 8'hFF);
    n0 = nrst;
    idle(6);
    check(nrst, n0);
    // The delayed reset is still pending here; the last halt left power-down set.
    rd(8'h10, 8'h06);
    idle(20);
    check(nrst, n0 + 1);
    rd(8'h04, 8'h01);
    rd(8'h00, 8'h57);
    wr(8'h04, 8'h00);
    rd(8'h04, 8'h00);
    wr(8'h08, 8'h33);
    idle(26);
    check(nrst, n0 + 2);
    rd(8'h04, 8'h02);
    rd(8'h08, 8'h5A);
    summarize();
  end
endmodule // testbench
